// ==== logic/ptt_pkg.sv ====
// ptt_pkg: constants and types shared by the periodic tick timer files.
// Assumes an 8-bit register port with 16-bit addresses on one clock.
package ptt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port geometry and offsets
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 8;
    localparam logic [15:0] CTRL_OFFSET = 16'h003C;
    localparam logic [15:0] MOD_OFFSET  = 16'h003D;

    ////////////////////////////////////////////////////////////////////////
    // control register field positions
    localparam int FLAG_BIT = 7;
    localparam int FRZ_BIT  = 6;
    localparam int MASK_BIT = 5;
    localparam int SWAI_BIT = 4;
    localparam int RSTP_BIT = 3;
    localparam int IE_BIT   = 2;
    localparam int RATE_HI  = 1;
    localparam int RATE_LO  = 0;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [7:0] MOD_RESET  = 8'h00;
    localparam logic [7:0] DATA_ZERO  = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // prescaler rate codes and their reload values (ratio minus one)
    localparam logic [1:0] RATE_OFF    = 2'h0;
    localparam logic [1:0] RATE_DIV1   = 2'h1;
    localparam logic [1:0] RATE_DIV16  = 2'h2;
    localparam logic [1:0] RATE_DIV256 = 2'h3;
    localparam logic [7:0] PRE_LOAD_DIV1   = 8'h00;
    localparam logic [7:0] PRE_LOAD_DIV16  = 8'h0F;
    localparam logic [7:0] PRE_LOAD_DIV256 = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // synchronisation and write-lock cycle counts
    localparam logic [1:0] LOCK_REF_LAST = 2'h2; // three reference ticks
    localparam logic [1:0] LOCK_BUS_LAST = 2'h1; // then two bus clocks

    ////////////////////////////////////////////////////////////////////////
    // state types
    typedef enum logic [1:0] {LOCK_IDLE, LOCK_REF, LOCK_BUS} ptt_lock_state_type;
    typedef enum logic {CNT_OFF, CNT_RUN} ptt_cnt_state_type;

endpackage : ptt_pkg

// ==== logic/ptt_sync2.sv ====
// ptt_sync2: two flip-flop synchroniser for one level.
// Assumes the input changes slower than the clock it is brought into.
`timescale 1ns/1ns
module ptt_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // level crossing in and out
    input  wire logic async_in,
    output logic      sync_out
);
    import ptt_pkg::*;

    logic meta;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds the second stage only
    always_ff @(posedge clk) begin
        if (srst) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : ptt_sync2

// ==== logic/ptt_lock.sv ====
// ptt_lock: write lock that spans three reference ticks plus two clocks.
// Assumes ref_tick is a one-cycle pulse per synchronised reference edge.
`timescale 1ns/1ns
module ptt_lock (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // lock start and reference pacing
    input  wire logic start,
    input  wire logic ref_tick,
    // lock status
    output logic      busy
);
    import ptt_pkg::*;

    ptt_lock_state_type state;
    ptt_lock_state_type next_state;
    logic [1:0]         cnt;
    logic [1:0]         next_cnt;

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= LOCK_IDLE;
            cnt   <= 2'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // count reference ticks, then bus clocks
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            LOCK_IDLE: begin
                if (start) begin
                    next_state = LOCK_REF;
                    next_cnt   = 2'h0;
                end
            end
            LOCK_REF: begin
                if (ref_tick) begin
                    next_cnt = cnt + 2'h1;
                    if (cnt == LOCK_REF_LAST) begin
                        next_state = LOCK_BUS;
                        next_cnt   = 2'h0;
                    end
                end
            end
            LOCK_BUS: begin
                next_cnt = cnt + 2'h1;
                if (cnt == LOCK_BUS_LAST) begin
                    next_state = LOCK_IDLE;
                end
            end
        endcase
    end

    assign busy = (state != LOCK_IDLE);

endmodule : ptt_lock

// ==== logic/ptt_timer.sv ====
// ptt_timer: periodic tick timer with control and modulus registers.
// Assumes a 10 MHz bus clock, a slower free reference clock on a pin,
// and mode inputs (special, wait, stop, debug) from logic on clk.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module ptt_timer (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // register port
    input  wire logic [ptt_pkg::ADDR_W-1:0] addr,
    input  wire logic [ptt_pkg::DATA_W-1:0] wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic [ptt_pkg::DATA_W-1:0]   rdata,
    // reference clock pin
    input  wire logic                    ref_clk_in,
    // chip modes
    input  wire logic                    special_mode,
    input  wire logic                    wait_mode,
    input  wire logic                    stop_mode,
    input  wire logic                    debug_active,
    // status outputs
    output logic                         irq,
    output logic                         counter_running
);
    import ptt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // register bank state
    logic       timeout_flag;
    logic       debug_freeze_bit;
    logic       wait_stop_bit;
    logic       stop_run_bit;
    logic       interrupt_enable_bit;
    logic [1:0] prescaler_rate_select;
    logic [7:0] periodic_tick_modulus;
    logic       once_used;

    // next values of the register bank
    logic       next_timeout_flag;
    logic       next_once_used;

    // decode
    wire        hit_ctrl;
    wire        hit_mod;
    wire        wr_ctrl;
    wire        wr_mod;
    wire        write_mask_bit;
    wire        ctrl_upd;
    wire        frz_we;
    wire        once_we;
    wire        rate_we;
    wire        mod_we;
    wire        flag_clr;
    wire        flag_set;
    wire [7:0]  ctrl_view;
    logic [7:0] next_rdata;

    // write locks
    logic       rate_busy;
    logic       mod_busy;

    // reference pacing
    logic       ref_sync;
    logic       ref_prev;
    wire        ref_tick;

    // counter side
    ptt_cnt_state_type cstate;
    ptt_cnt_state_type next_cstate;
    logic [7:0] pre_cnt;
    logic [7:0] next_pre_cnt;
    logic [7:0] mod_cnt;
    logic [7:0] next_mod_cnt;
    logic [1:0] cur_rate;
    logic [1:0] next_cur_rate;
    logic       timeout_evt;
    logic       next_timeout_evt;
    logic [1:0] flag_pipe;
    wire        cfg_off;
    wire        hold;
    wire        reinit;

    ////////////////////////////////////////////////////////////////////////
    // prescaler reload for a rate code
    function automatic logic [7:0] pre_reload(input logic [1:0] rate);
        logic [7:0] val;
        val = PRE_LOAD_DIV1;
        unique case (rate)
            RATE_OFF:    val = PRE_LOAD_DIV1;
            RATE_DIV1:   val = PRE_LOAD_DIV1;
            RATE_DIV16:  val = PRE_LOAD_DIV16;
            RATE_DIV256: val = PRE_LOAD_DIV256;
        endcase
        return val;
    endfunction : pre_reload

    ////////////////////////////////////////////////////////////////////////
    // address decode and write qualification
    assign hit_ctrl       = (addr == CTRL_OFFSET);
    assign hit_mod        = (addr == MOD_OFFSET);
    assign wr_ctrl        = wr & hit_ctrl;
    assign wr_mod         = wr & hit_mod;
    assign write_mask_bit = wdata[MASK_BIT];

    // an unmasked control write touches flag and bits 4..0
    assign ctrl_upd = wr_ctrl & ~write_mask_bit;

    // freeze bit: free in special modes, set-only otherwise
    assign frz_we = wr_ctrl & (special_mode | wdata[FRZ_BIT]);

    // write-once bits; a masked write leaves the allowance intact
    assign once_we = ctrl_upd & (special_mode | ~once_used);

    // rate field and modulus ignore writes while synchronising
    assign rate_we = ctrl_upd & ~rate_busy;
    assign mod_we  = wr_mod & ~mod_busy;

    // flag: write one clears, nothing written sets it
    assign flag_clr = ctrl_upd & wdata[FLAG_BIT];
    assign flag_set = flag_pipe[1];

    ////////////////////////////////////////////////////////////////////////
    // control register fields
    always_ff @(posedge clk) begin
        if (srst) begin
            debug_freeze_bit      <= 1'b0;
            wait_stop_bit         <= 1'b0;
            stop_run_bit          <= 1'b0;
            interrupt_enable_bit  <= 1'b0;
            prescaler_rate_select <= RATE_RESET;
            periodic_tick_modulus <= MOD_RESET;
        end else begin
            if (frz_we) begin
                debug_freeze_bit <= wdata[FRZ_BIT];
            end
            if (once_we) begin
                wait_stop_bit <= wdata[SWAI_BIT];
                stop_run_bit  <= wdata[RSTP_BIT];
            end
            if (ctrl_upd) begin
                interrupt_enable_bit <= wdata[IE_BIT];
            end
            if (rate_we) begin
                prescaler_rate_select <= wdata[RATE_HI:RATE_LO];
            end
            if (mod_we) begin
                periodic_tick_modulus <= wdata;
            end
        end
    end

    // flag and write-once bookkeeping; a set beats a clear
    always_comb begin
        next_timeout_flag = flag_set | (timeout_flag & ~flag_clr);
        next_once_used    = once_used | (ctrl_upd & ~special_mode);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timeout_flag <= 1'b0;
            once_used    <= 1'b0;
        end else begin
            timeout_flag <= next_timeout_flag;
            once_used    <= next_once_used;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; mask bit always reads as zero
    assign ctrl_view = {timeout_flag, debug_freeze_bit, 1'b0,
                        wait_stop_bit, stop_run_bit, interrupt_enable_bit,
                        prescaler_rate_select};

    // data valid only in the cycle after the read strobe
    always_comb begin
        next_rdata = DATA_ZERO;
        if (rd & hit_ctrl) begin
            next_rdata = ctrl_view;
        end else if (rd & hit_mod) begin
            next_rdata = periodic_tick_modulus;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= DATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference clock brought in and turned into a tick per rising edge
    ptt_sync2 u_ref_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (ref_clk_in),
        .sync_out (ref_sync)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= ref_sync;
        end
    end

    assign ref_tick = ref_sync & ~ref_prev;

    ////////////////////////////////////////////////////////////////////////
    // write locks, one for the rate field and one for the modulus
    ptt_lock u_rate_lock (
        .clk      (clk),
        .srst     (srst),
        .start    (rate_we),
        .ref_tick (ref_tick),
        .busy     (rate_busy)
    );

    ptt_lock u_mod_lock (
        .clk      (clk),
        .srst     (srst),
        .start    (mod_we),
        .ref_tick (ref_tick),
        .busy     (mod_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // counter conditions
    // rate 01 with modulus zero is treated as off as well
    assign cfg_off = (prescaler_rate_select == RATE_OFF) |
                     ((prescaler_rate_select == RATE_DIV1) &
                      (periodic_tick_modulus == MOD_RESET));
    assign hold    = (debug_active & debug_freeze_bit) |
                     (stop_mode & ~stop_run_bit);
    assign reinit  = wait_mode & wait_stop_bit;

    // prescaler then modulus down counter, advanced once per ref tick
    always_comb begin
        next_cstate      = cstate;
        next_pre_cnt     = pre_cnt;
        next_mod_cnt     = mod_cnt;
        next_cur_rate    = cur_rate;
        next_timeout_evt = 1'b0;
        if (cfg_off | reinit) begin
            next_cstate = CNT_OFF;
        end else if (ref_tick & ~hold) begin
            unique case (cstate)
                CNT_OFF: begin
                    // leaving off loads a whole fresh period
                    next_cstate   = CNT_RUN;
                    next_cur_rate = prescaler_rate_select;
                    next_pre_cnt  = pre_reload(prescaler_rate_select);
                    next_mod_cnt  = periodic_tick_modulus;
                end
                CNT_RUN: begin
                    if (pre_cnt != 8'h00) begin
                        next_pre_cnt = pre_cnt - 8'h01;
                    end else if (mod_cnt != 8'h00) begin
                        next_mod_cnt = mod_cnt - 8'h01;
                        next_pre_cnt = pre_reload(cur_rate);
                    end else begin
                        // period end: pick up whatever is current now
                        next_timeout_evt = 1'b1;
                        next_cur_rate    = prescaler_rate_select;
                        next_pre_cnt     = pre_reload(prescaler_rate_select);
                        next_mod_cnt     = periodic_tick_modulus;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cstate      <= CNT_OFF;
            pre_cnt     <= 8'h00;
            mod_cnt     <= 8'h00;
            cur_rate    <= RATE_RESET;
            timeout_evt <= 1'b0;
        end else begin
            cstate      <= next_cstate;
            pre_cnt     <= next_pre_cnt;
            mod_cnt     <= next_mod_cnt;
            cur_rate    <= next_cur_rate;
            timeout_evt <= next_timeout_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timeout handed back to the register side over two stages
    // keeps the same latency as a true cross-domain return path
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_pipe <= 2'h0;
        end else begin
            flag_pipe <= {flag_pipe[0], timeout_evt};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign irq             = timeout_flag & interrupt_enable_bit;
    assign counter_running = (cstate == CNT_RUN);

endmodule : ptt_timer

// ==== verification/ptt_timer_checker.sv ====
// ptt_timer_checker: port-level assertions for the periodic tick timer.
// Assumes one clock and srst synchronous active high; bound onto ptt_timer.
`timescale 1ns/1ns
module ptt_timer_checker (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        srst,
    // register port
    input wire logic [ptt_pkg::ADDR_W-1:0] addr,
    input wire logic [ptt_pkg::DATA_W-1:0] wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [ptt_pkg::DATA_W-1:0] rdata,
    // status
    input wire logic                        irq,
    input wire logic                        counter_running
);
    import ptt_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // decoded strobes
    wire logic ctl_rd = rd && addr == CTRL_OFFSET;
    wire logic ctl_wr = wr && addr == CTRL_OFFSET;
    wire logic map_rd = ctl_rd || (rd && addr == MOD_OFFSET);

    ////////////////////////////////////////////////////////////////////////
    // read port
    rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (rd && !map_rd |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    mask_rd_a: assert property (ctl_rd |=> !rdata[MASK_BIT])
        else $error("mask bit read back as one");
    irq_flag_a: assert property (ctl_rd |=> (rdata[7] && rdata[2]) == $past(irq))
        else $error("irq differs from flag and enable");
    // rate zero seen on read: counter must be stopped soon after
    rate_off_a: assert property ($past(ctl_rd) && rdata[1:0] == RATE_OFF
        |-> ##[0:4] !counter_running) else $error("counter runs with rate off");

    ////////////////////////////////////////////////////////////////////////
    // control writes
    // a timeout landing with the clear wins; the flag set trails a running cycle by three
    flag_clear_a: assert property (ctl_wr && !wdata[5] && wdata[7]
        && !$past(counter_running, 3) |=> !irq) else $error("write one did not clear flag");
    ie_zero_a: assert property (ctl_wr && !wdata[5] && !wdata[2] |=> !irq)
        else $error("irq with enable cleared");
    mask_hold_a: assert property (ctl_wr && wdata[5] && irq |=> irq)
        else $error("masked write changed flag or enable");
    // reset outranks everything, so no disable here
    reset_clear_a: assert property (disable iff (1'b0) srst
        |=> rdata == 8'h00 && !irq && !counter_running) else $error("reset not clean");

    // main scenarios reached
    irq_c: cover property ($rose(irq));
    run_c: cover property ($rose(counter_running));
    masked_c: cover property (ctl_wr && wdata[5]);
endmodule : ptt_timer_checker

bind ptt_timer ptt_timer_checker u_chk (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .counter_running(counter_running)
);

// ==== verification/ptt_cpu_model.sv ====
// ptt_cpu_model: software side of the register port, as bus tasks.
// Assumes a slave that never stalls and the reference period below.
`timescale 1ns/1ns
module ptt_cpu_model #(
    parameter int REF_CLKS = 10
) (
    // clock
    input  wire logic                        clk,
    // register port
    output logic [ptt_pkg::ADDR_W-1:0]      addr,
    output logic [ptt_pkg::DATA_W-1:0]      wdata,
    output logic                             wr,
    output logic                             rd,
    input  wire logic [ptt_pkg::DATA_W-1:0] rdata
);
    import ptt_pkg::*;

    // idle bus; address and data are scrambled between transfers
    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one-cycle write, returns once the edge has landed
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        #1;
    endtask : wr_reg

    // one-cycle read, data taken in the following cycle
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask : rd_reg

    // no visible lock flag, so software waits out the worst case
    task automatic lock_wait;
        repeat (4 * REF_CLKS + 5) @(posedge clk);
    endtask : lock_wait
endmodule : ptt_cpu_model

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for ptt_timer with a software model.
// Assumes a 10 MHz clk and a free reference clock of ten clk periods.
`timescale 1ns/1ns
module tb_top;
    import ptt_pkg::*;
    localparam int REF_CLKS = 10;

    // stimulus and wiring
    logic              clk          = 1'b0;
    logic              srst         = 1'b1;
    logic              ref_clk_in   = 1'b0;
    logic              special_mode = 1'b0;
    logic [2:0]        mode         = 3'h0; // debug, stop, wait
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              counter_running;
    int                error_cnt    = 0;
    int                total_checks = 0;
    int                cyc          = 0;

    ptt_cpu_model #(.REF_CLKS(REF_CLKS)) cpu (.clk(clk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    ptt_timer dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ref_clk_in(ref_clk_in), .special_mode(special_mode),
        .wait_mode(mode[0]), .stop_mode(mode[1]), .debug_active(mode[2]),
        .irq(irq), .counter_running(counter_running));

    // clocks; the odd offset keeps the reference out of phase with clk
    initial forever #50 clk = ~clk;
    initial begin
        #237;
        forever #500 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // edges until irq is seen high, at most max
    task automatic wait_irq(input int max, output int n);
        n = 0;
        while (n < max && irq !== 1'b1) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] d;
        cpu.wr_reg(16'h003B, 8'hFF);
        cpu.rd_reg(CTRL_OFFSET, d);
        check(d, 8'h00);
        cpu.rd_reg(MOD_OFFSET, d);
        check(d, 8'h00);
        cpu.rd_reg(16'h003B, d);
        check(d, 8'h00);
        check({irq, counter_running}, 2'h0);
    endtask : t_reset

    // write-once and debug-freeze rules, normal then special mode
    task automatic t_once;
        logic [7:0] w [5] = '{8'h38, 8'h08, 8'h50, 8'h08, 8'h10};
        logic [7:0] e [5] = '{8'h00, 8'h08, 8'h48, 8'h48, 8'h10};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            if (i == 4)
                special_mode <= 1'b1;
            cpu.wr_reg(CTRL_OFFSET, w[i]);
            cpu.rd_reg(CTRL_OFFSET, d);
            check(d, e[i]);
        end
        cpu.wr_reg(CTRL_OFFSET, 8'h00);
    endtask : t_once

    // a second write inside the lock is dropped
    task automatic t_lock;
        logic [7:0] d;
        cpu.lock_wait();
        cpu.wr_reg(MOD_OFFSET, 8'h05);
        cpu.wr_reg(MOD_OFFSET, 8'h02);
        cpu.wr_reg(CTRL_OFFSET, 8'h02);
        cpu.wr_reg(CTRL_OFFSET, 8'h03);
        cpu.lock_wait();
        cpu.rd_reg(MOD_OFFSET, d);
        check(d, 8'h05);
        cpu.rd_reg(CTRL_OFFSET, d);
        check(d[1:0], 2'h2);
    endtask : t_lock

    // rate 01 with modulus zero kept off, then period between two timeouts for three rate and modulus pairs
    task automatic t_rate;
        logic [1:0] rt [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
        logic [7:0] md [4] = '{8'h00, 8'h02, 8'h01, 8'h00};
        int         tk [4] = '{0, 3, 32, 256};
        int         n;
        for (int i = 0; i < 4; i++) begin
            cpu.wr_reg(CTRL_OFFSET, 8'h84);
            cpu.lock_wait();
            cpu.wr_reg(MOD_OFFSET, md[i]);
            cpu.lock_wait();
            cpu.wr_reg(CTRL_OFFSET, {6'h21, rt[i]});
            if (tk[i] == 0) begin
                repeat (60) @(posedge clk);
                check(counter_running, 1'b0);
            end else begin
                wait_irq(tk[i] * REF_CLKS + 40, n);
                cpu.wr_reg(CTRL_OFFSET, {6'h21, rt[i]});
                wait_irq(tk[i] * REF_CLKS + 40, n);
                check(16'(n + 2), 16'(tk[i] * REF_CLKS));
            end
        end
    endtask : t_rate

    // wait, stop and debug, each with its control bit set and cleared
    task automatic t_modes;
        logic [7:0] k [6] = '{8'h10, 8'h00, 8'h00, 8'h08, 8'h40, 8'h00};
        logic [2:0] m [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
        logic       r [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        int         n;
        cpu.wr_reg(CTRL_OFFSET, 8'h84);
        cpu.lock_wait();
        cpu.wr_reg(MOD_OFFSET, 8'h01);
        cpu.lock_wait();
        for (int i = 0; i < 6; i++) begin
            cpu.wr_reg(CTRL_OFFSET, k[i] | 8'h85);
            mode <= m[i];
            repeat (5) @(posedge clk);
            cpu.wr_reg(CTRL_OFFSET, k[i] | 8'h85);
            wait_irq(60, n);
            check(irq, r[i]);
            mode <= 3'h0;
        end
    endtask : t_modes

    // flag writes of zero, masked writes and the enable
    task automatic t_flag;
        logic [7:0] d;
        int         n;
        wait_irq(60, n);
        cpu.wr_reg(CTRL_OFFSET, 8'h05);
        check(irq, 1'b1);
        cpu.wr_reg(CTRL_OFFSET, 8'hA0);
        check(irq, 1'b1);
        cpu.rd_reg(CTRL_OFFSET, d);
        check(d, 8'h85);
        cpu.wr_reg(CTRL_OFFSET, 8'h81);
        check(irq, 1'b0);
        repeat (60) @(posedge clk);
        check(irq, 1'b0);
        cpu.rd_reg(CTRL_OFFSET, d);
        check(d, 8'h81);
    endtask : t_flag

    ////////////////////////////////////////////////////////////////////////
    // main sequence, ending with a reset in mid-run
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_once();
        t_lock();
        t_rate();
        t_modes();
        t_flag();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        end_sim();
    end

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            end_sim();
        end
    end
endmodule : tb_top
